// ---- pkg/tpc_cfg.svh ----
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ****************************************************************
// Link addressing.
// ****************************************************************
`define TPC_SLAVE_ADDR  7'h51
`define TPC_ADDR_RD     8'ha2
`define TPC_ADDR_WR     8'ha3
`define TPC_LAST_BIT    4'd7

// ****************************************************************
// Register indexes and reset values.
// ****************************************************************
`define TPC_IDX_CFG     8'h00
`define TPC_IDX_YL      8'h08
`define TPC_IDX_YH      8'h09
`define TPC_IDX_XL      8'h0a
`define TPC_IDX_XH      8'h0b
`define TPC_IDX_EVT     8'h0c
`define TPC_CFG_RST     8'h01
`define TPC_CFG_EN      0

// ****************************************************************
// Measurement and timing.
// ****************************************************************
`define TPC_COORD_W     10
`define TPC_NOPRESS_MAX 10'h3a0
`define TPC_CNT_W       24
`define TPC_IRQ_W       8
`define TPC_CLK_MHZ     100
`define TPC_REPEAT_MS   50
`define TPC_SCAN_US     1000
`define TPC_IRQ_NS      1000

`endif

// ---- pkg/tpc_pkg.sv ----
`include "tpc_cfg.svh"

package tpc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } tpc_fsm_t;

    typedef enum logic [3:0] {
        EV_NONE   = 4'h0,
        EV_DOWN   = 4'h1,
        EV_REPEAT = 4'h2,
        EV_UP     = 4'h3
    } tpc_ev_t;

    typedef struct packed {
        tpc_fsm_t                 st;
        logic [3:0]               cnt;
        logic [7:0]               rx;
        logic [7:0]               tx;
        logic [7:0]               idx;
        logic                     rd;
        logic                     first;
        logic                     ack_on;
        logic                     sda_oe;
        logic                     sda_o;
        logic                     scl_q;
        logic                     sda_q;
        logic                     tgl_q;
        logic [7:0]               cfg;
        logic [`TPC_COORD_W-1:0]  x;
        logic [`TPC_COORD_W-1:0]  y;
        logic [`TPC_COORD_W-1:0]  ys;
        logic                     pen;
        tpc_ev_t                  ev;
        logic                     axis;
        logic                     start;
        logic                     busy;
        logic [`TPC_CNT_W-1:0]    scan_cnt;
        logic [`TPC_CNT_W-1:0]    rep_cnt;
        logic [`TPC_IRQ_W-1:0]    irq_cnt;
        logic                     irq;
    } tpc_state_t;

endpackage

// ---- rtl/tpc_sync.sv ----
`timescale 1ns/1ns

module tpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tpc_sync_t;

    tpc_sync_t s_r;
    tpc_sync_t s_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;

endmodule

// ---- rtl/tpc_link.sv ----
`timescale 1ns/1ns

module tpc_link (
    input  wire logic scl_clk,
    input  wire logic rst,
    input  wire logic sda,
    output logic      bit_q,
    output logic      tgl_q
);

    typedef struct packed {
        logic bitv;
        logic tgl;
    } tpc_link_t;

    tpc_link_t s_r;
    tpc_link_t s_nxt;

    // Each rising edge of the bus clock captures one data bit and flips the
    // toggle; the bit stays put until the next rising edge, which is what
    // lets the system side pick it up once the toggle has crossed over.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.bitv = sda;
        s_nxt.tgl  = ~s_r.tgl;
    end

    // The bus clock stands still between frames, so a reset sampled on it
    // would never arrive and would swallow the first bits of the next frame.
    // The reset therefore acts at once and is released while the clock idles.
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bit_q = s_r.bitv;
    assign tgl_q = s_r.tgl;

endmodule

// ---- rtl/tpc_ctrl.sv ----
// Behaviour
// - Device is a bus slave answering only to seven-bit address 0x51.
// - Address byte 0xa2 starts a read, 0xa3 starts a write.
// - First byte of a write is latched as the register index.
// - A read returns one register byte per byte clocked by the master.
// - Scanning of both axes starts by itself after reset.
// - Pen-down and pen-up edges detected; repeat event twenty times a second.
// - Interrupt output pulses on every pen-down, repeat or pen-up event.
// - Config index 0x00 bit 0 enables scanning; reset value 0x01.
// - Event register 0x0c holds latest event code in bits 3..0.
// - Six registers; only the config register is writable.
// - Unused config bits reset to zero but read back as written; high-byte bits read as zero.
// - Axis values above 0x3a0 mean no press; coordinates are not updated.
`timescale 1ns/1ns
`include "tpc_cfg.svh"

module tpc_ctrl #(
    parameter int SCAN_CYC   = `TPC_SCAN_US * `TPC_CLK_MHZ,
    parameter int REPEAT_CYC = `TPC_REPEAT_MS * 1000 * `TPC_CLK_MHZ
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    scl_clk,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    input  wire logic                    samp_valid,
    input  wire logic [`TPC_COORD_W-1:0] samp_data,
    output logic                         scan_start,
    output logic                         scan_axis,
    output logic                         touch_irq_out
);

    // ****************************************************************
    // Timing counts.
    // ****************************************************************
    localparam int IRQ_CYC = (`TPC_IRQ_NS * `TPC_CLK_MHZ + 999) / 1000;

    localparam logic [`TPC_CNT_W-1:0] SCAN_LAST = `TPC_CNT_W'(SCAN_CYC - 1);
    localparam logic [`TPC_CNT_W-1:0] REP_LAST  = `TPC_CNT_W'(REPEAT_CYC - 1);
    localparam logic [`TPC_IRQ_W-1:0] IRQ_LEN   = `TPC_IRQ_W'(IRQ_CYC);

    // ****************************************************************
    // State.
    // ****************************************************************
    tpc_pkg::tpc_state_t s_r;
    tpc_pkg::tpc_state_t s_nxt;

    logic       link_bit;
    logic       link_tgl;
    logic [2:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       tgl_s;

    // ****************************************************************
    // Bus clock domain and synchronisers.
    // ****************************************************************
    tpc_link u_link (
        .scl_clk (scl_clk),
        .rst     (rst),
        .sda     (sda_in),
        .bit_q   (link_bit),
        .tgl_q   (link_tgl)
    );

    tpc_sync #(
        .W (3)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({scl_clk, sda_in, link_tgl}),
        .q   (pins_s)
    );

    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign tgl_s = pins_s[0];

    // ****************************************************************
    // Register read decode.
    // ****************************************************************
    function automatic logic [7:0] reg_read(
        input logic [7:0]          idx,
        input tpc_pkg::tpc_state_t st
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `TPC_IDX_CFG: v = st.cfg;
            `TPC_IDX_YL:  v = st.y[7:0];
            `TPC_IDX_YH:  v = {6'h00, st.y[`TPC_COORD_W-1:8]};
            `TPC_IDX_XL:  v = st.x[7:0];
            `TPC_IDX_XH:  v = {6'h00, st.x[`TPC_COORD_W-1:8]};
            `TPC_IDX_EVT: v = {4'h0, st.ev};
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        logic                    bit_ev;
        logic                    fall;
        logic                    start_c;
        logic                    stop_c;
        logic [7:0]              rx_new;
        logic [7:0]              rd_byte;
        logic                    press;
        logic                    new_ev;
        tpc_pkg::tpc_ev_t        ev_code;

        s_nxt   = s_r;
        bit_ev  = tgl_s != s_r.tgl_q;
        fall    = s_r.scl_q & ~scl_s;
        start_c = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
        stop_c  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
        rx_new  = {s_r.rx[6:0], link_bit};
        rd_byte = reg_read(s_r.idx, s_r);
        press   = 1'b0;
        new_ev  = 1'b0;
        ev_code = tpc_pkg::EV_NONE;

        s_nxt.scl_q = scl_s;
        s_nxt.sda_q = sda_s;
        s_nxt.tgl_q = tgl_s;
        s_nxt.start = 1'b0;
        s_nxt.sda_o = 1'b0;

        // ************************************************************
        // Bus protocol engine.
        // ************************************************************
        if (start_c) begin
            // A repeated start lands here as well and restarts the frame.
            s_nxt.st     = tpc_pkg::ST_ADDR;
            s_nxt.cnt    = 4'h0;
            s_nxt.ack_on = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_c) begin
            s_nxt.st     = tpc_pkg::ST_IDLE;
            s_nxt.ack_on = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end else begin
            if (bit_ev) begin
                unique case (s_r.st)
                    tpc_pkg::ST_ADDR: begin
                        s_nxt.rx  = rx_new;
                        s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                        if (s_r.cnt == `TPC_LAST_BIT) begin
                            if (rx_new[7:1] == `TPC_SLAVE_ADDR) begin
                                s_nxt.rd    = rx_new == `TPC_ADDR_RD;
                                s_nxt.first = rx_new == `TPC_ADDR_WR;
                                s_nxt.st    = tpc_pkg::ST_ACK;
                            end else begin
                                s_nxt.st = tpc_pkg::ST_IDLE;
                            end
                        end
                    end
                    tpc_pkg::ST_WDATA: begin
                        s_nxt.rx  = rx_new;
                        s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                        if (s_r.cnt == `TPC_LAST_BIT) begin
                            s_nxt.st = tpc_pkg::ST_ACK;
                            if (s_r.first) begin
                                s_nxt.idx   = rx_new;
                                s_nxt.first = 1'b0;
                            end else begin
                                if (s_r.idx == `TPC_IDX_CFG) begin
                                    s_nxt.cfg = rx_new;
                                end
                                s_nxt.idx = 8'(s_r.idx + 8'h01);
                            end
                        end
                    end
                    tpc_pkg::ST_RDATA: begin
                        s_nxt.tx  = {s_r.tx[6:0], 1'b0};
                        s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                        if (s_r.cnt == `TPC_LAST_BIT) begin
                            s_nxt.st = tpc_pkg::ST_RACK;
                        end
                    end
                    tpc_pkg::ST_RACK: begin
                        // A low bit is the master asking for one more byte.
                        if (!link_bit) begin
                            s_nxt.tx  = rd_byte;
                            s_nxt.idx = 8'(s_r.idx + 8'h01);
                            s_nxt.cnt = 4'h0;
                            s_nxt.st  = tpc_pkg::ST_RDATA;
                        end else begin
                            s_nxt.st = tpc_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (fall) begin
                unique case (s_r.st)
                    tpc_pkg::ST_ACK: begin
                        if (!s_r.ack_on) begin
                            s_nxt.ack_on = 1'b1;
                            s_nxt.sda_oe = 1'b1;
                        end else begin
                            s_nxt.ack_on = 1'b0;
                            s_nxt.cnt    = 4'h0;
                            if (s_r.rd) begin
                                s_nxt.tx     = rd_byte;
                                s_nxt.idx    = 8'(s_r.idx + 8'h01);
                                s_nxt.sda_oe = ~rd_byte[7];
                                s_nxt.st     = tpc_pkg::ST_RDATA;
                            end else begin
                                s_nxt.sda_oe = 1'b0;
                                s_nxt.st     = tpc_pkg::ST_WDATA;
                            end
                        end
                    end
                    tpc_pkg::ST_RDATA: begin
                        s_nxt.sda_oe = ~s_r.tx[7];
                    end
                    default: begin
                        s_nxt.sda_oe = 1'b0;
                    end
                endcase
            end
        end

        // ************************************************************
        // Scan sequencing.
        // ************************************************************
        if (!s_r.busy) begin
            if (s_r.cfg[`TPC_CFG_EN]) begin
                if (s_r.scan_cnt == SCAN_LAST) begin
                    s_nxt.scan_cnt = '0;
                    s_nxt.busy     = 1'b1;
                    s_nxt.axis     = 1'b0;
                    s_nxt.start    = 1'b1;
                end else begin
                    s_nxt.scan_cnt = `TPC_CNT_W'(s_r.scan_cnt + 1'b1);
                end
            end
        end else if (samp_valid) begin
            if (!s_r.axis) begin
                s_nxt.ys    = samp_data;
                s_nxt.axis  = 1'b1;
                s_nxt.start = 1'b1;
            end else begin
                s_nxt.busy = 1'b0;
                press = (s_r.ys <= `TPC_NOPRESS_MAX) &&
                        (samp_data <= `TPC_NOPRESS_MAX);
                if (press) begin
                    s_nxt.y = s_r.ys;
                    s_nxt.x = samp_data;
                end
                if (press && !s_r.pen) begin
                    new_ev  = 1'b1;
                    ev_code = tpc_pkg::EV_DOWN;
                end else if (!press && s_r.pen) begin
                    new_ev  = 1'b1;
                    ev_code = tpc_pkg::EV_UP;
                end
                s_nxt.pen = press;
            end
        end

        // ************************************************************
        // Pen-down repeat timer.
        // ************************************************************
        // The repeat period restarts at every pen-down, so the first
        // repeat follows the down event by one full period.
        if (!s_r.pen || new_ev || !s_r.cfg[`TPC_CFG_EN]) begin
            s_nxt.rep_cnt = '0;
        end else if (s_r.rep_cnt == REP_LAST) begin
            s_nxt.rep_cnt = '0;
            new_ev        = 1'b1;
            ev_code       = tpc_pkg::EV_REPEAT;
        end else begin
            s_nxt.rep_cnt = `TPC_CNT_W'(s_r.rep_cnt + 1'b1);
        end

        // ************************************************************
        // Event register and interrupt pulse.
        // ************************************************************
        if (new_ev) begin
            s_nxt.ev      = ev_code;
            s_nxt.irq     = 1'b1;
            s_nxt.irq_cnt = IRQ_LEN;
        end else if (s_r.irq_cnt > `TPC_IRQ_W'(1)) begin
            s_nxt.irq_cnt = `TPC_IRQ_W'(s_r.irq_cnt - 1'b1);
        end else begin
            s_nxt.irq_cnt = '0;
            s_nxt.irq     = 1'b0;
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r     <= '0;
            s_r.cfg <= `TPC_CFG_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign sda_out       = s_r.sda_o;
    assign sda_oe        = s_r.sda_oe;
    assign scan_start    = s_r.start;
    assign scan_axis     = s_r.axis;
    assign touch_irq_out = s_r.irq;

endmodule

// ---- sim/tpc_ctrl_properties.sv ----
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_ctrl_properties #(
    parameter int SCAN_CYC   = 20,
    parameter int REPEAT_CYC = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic samp_valid,
    input wire logic scan_start,
    input wire logic scan_axis,
    input wire logic touch_irq_out
);
    localparam int SCAN_LIM = SCAN_CYC + 8;
    localparam int IRQ_CYC  = `TPC_IRQ_NS * `TPC_CLK_MHZ / 1000;
    logic [15:0] hi_cnt_r;

    // Counts how long the interrupt has stood high; a retrigger is not expected here.
    always_ff @(posedge clk) begin
        if (rst || !touch_irq_out) begin
            hi_cnt_r <= 16'h0000;
        end else begin
            hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_irq_len;
        $fell(touch_irq_out) |-> hi_cnt_r == 16'(IRQ_CYC);
    endproperty
    a_irq_len: assert property (p_irq_len) else $error("interrupt pulse length wrong");
    property p_irq_min;
        $rose(touch_irq_out) |-> touch_irq_out [*8];
    endproperty
    a_irq_min: assert property (p_irq_min) else $error("interrupt pulse too short");
    property p_first_scan;
        $fell(rst) |-> ##[1:SCAN_LIM] (scan_start && !scan_axis);
    endproperty
    a_first_scan: assert property (p_first_scan) else $error("no scan after reset");
    property p_x_after_y;
        samp_valid && !scan_axis |=> scan_start && scan_axis;
    endproperty
    a_x_after_y: assert property (p_x_after_y) else $error("second axis not started");
    property p_start_pulse;
        scan_start |=> !scan_start || $rose(scan_axis);
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("scan start longer than a cycle");
    property p_axis_hold;
        $fell(scan_axis) |-> scan_start;
    endproperty
    a_axis_hold: assert property (p_axis_hold) else $error("axis dropped without a new scan");
    property p_y_first;
        $rose(scan_axis) |-> scan_start && $past(samp_valid);
    endproperty
    a_y_first: assert property (p_y_first) else $error("x axis started without y sample");
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl_clk;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data line moved with clock high");
    property p_sda_out_low;
        sda_out == 1'b0;
    endproperty
    a_sda_out_low: assert property (p_sda_out_low) else $error("data line driven high");
endmodule

bind tpc_ctrl tpc_ctrl_properties #(
    .SCAN_CYC   (SCAN_CYC),
    .REPEAT_CYC (REPEAT_CYC)
) i_tpc_ctrl_properties (
    .clk           (clk),
    .rst           (rst),
    .scl_clk       (scl_clk),
    .sda_out       (sda_out),
    .sda_oe        (sda_oe),
    .samp_valid    (samp_valid),
    .scan_start    (scan_start),
    .scan_axis     (scan_axis),
    .touch_irq_out (touch_irq_out)
);

// ---- sim/tpc_host.sv ----
`timescale 1ns/1ns
module tpc_host #(
    parameter int H = 20
) (
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    logic lk = 1'b0;

    // Base tick of the link; the clock line is made from it and stands high between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        #1;
        forever #3 lk = ~lk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lk);
    endtask
    // Data moves only while the clock is low, so no false start or stop is seen.
    task automatic bitx(input logic b, output logic r);
        tick(4);
        sda_low = !b;
        tick(H);
        scl = 1'b1;
        tick(H);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        tick(4);
        sda_low = 1'b0;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_low = 1'b1;
        tick(H);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(4);
        sda_low = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_low = 1'b0;
        tick(H);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(last, r);
    endtask
endmodule

// ---- sim/tpc_ctrl_bench.sv ----
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_ctrl_bench;
    localparam int REP = 3000;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic       scl;
    logic       host_low;
    logic       sda_out;
    logic       sda_oe;
    logic       samp_valid = 1'b0;
    logic [9:0] samp_data = 10'h000;
    logic       scan_start;
    logic       scan_axis;
    logic       touch_irq_out;
    logic [9:0] x_val = 10'h3ff;
    logic [9:0] y_val = 10'h3ff;
    logic [7:0] rb [16];
    int         errors = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         t_down;
    wire        sda_w = !host_low && (sda_oe ? sda_out : 1'b1);

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Converter stand-in: answers each start one cycle later with the axis value.
    always @(negedge clk) begin
        samp_valid <= scan_start;
        samp_data <= scan_axis ? x_val : y_val;
    end

    tpc_ctrl #(.SCAN_CYC(20), .REPEAT_CYC(REP)) i_tpc_ctrl (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .scl_clk       (scl),
        .sda_in        (sda_w),
        .sda_out       (sda_out),
        .sda_oe        (sda_oe),
        .samp_valid    (samp_valid),
        .samp_data     (samp_data),
        .scan_start    (scan_start),
        .scan_axis     (scan_axis),
        .touch_irq_out (touch_irq_out)
    );
    tpc_host i_tpc_host (
        .sda     (sda_w),
        .scl     (scl),
        .sda_low (host_low)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tx(input logic [7:0] b);
        logic a;
        i_tpc_host.wbyte(b, a);
        check(a, 1'b1);
    endtask
    task automatic rd(input logic [7:0] idx, input int n);
        i_tpc_host.start();
        tx(`TPC_ADDR_WR);
        tx(idx);
        i_tpc_host.start();
        tx(`TPC_ADDR_RD);
        for (int i = 0; i < n; i++) i_tpc_host.rbyte(i == n - 1, rb[i]);
        i_tpc_host.stop();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_tpc_host.start();
        tx(`TPC_ADDR_WR);
        tx(idx);
        tx(d);
        i_tpc_host.stop();
    endtask
    task automatic wait_irq();
        for (int i = 0; i < REP + 200; i++) begin
            @(negedge clk);
            if (touch_irq_out === 1'b1) return;
        end
        errors++;
        summarize();
    endtask
    task automatic chk5(input logic [39:0] e);
        for (int i = 0; i < 5; i++) check(rb[i], e[39-8*i -: 8]);
    endtask
    task automatic starts(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(negedge clk);
            if (scan_start === 1'b1) k++;
        end
    endtask

    task automatic s_reset_vals();
        rd(`TPC_IDX_CFG, 14);
        for (int i = 0; i < 14; i++) check(rb[i], (i == 0) ? 8'h01 : 8'h00);
    endtask
    task automatic s_foreign();
        logic a;
        i_tpc_host.start();
        i_tpc_host.wbyte(8'ha4, a);
        check(a, 1'b0);
        i_tpc_host.stop();
    endtask
    task automatic s_press();
        y_val = 10'h3a0;
        x_val = 10'h1c3;
        wait_irq();
        t_down = cyc;
        rd(`TPC_IDX_YL, 5);
        chk5(40'ha0_03_c3_01_01);
    endtask
    task automatic s_repeat();
        wait_irq();
        check((cyc - t_down > REP - 30) && (cyc - t_down < REP + 30), 1'b1);
        rd(`TPC_IDX_EVT, 1);
        check(rb[0], 8'h02);
    endtask
    task automatic s_release();
        x_val = 10'h3a1;
        wait_irq();
        rd(`TPC_IDX_YL, 5);
        chk5(40'ha0_03_c3_01_03);
    endtask
    task automatic s_config();
        int k;
        logic a;
        wr(`TPC_IDX_CFG, 8'hfe);
        repeat (20) @(negedge clk);
        starts(200, k);
        check(k, 0);
        rd(`TPC_IDX_CFG, 1);
        check(rb[0], 8'hfe);
        wr(`TPC_IDX_XL, 8'h55);
        wr(8'h05, 8'h77);
        rd(`TPC_IDX_XL, 1);
        check(rb[0], 8'hc3);
        rd(8'h05, 1);
        check(rb[0], 8'h00);
        @(negedge clk);
        ce = 1'b0;
        i_tpc_host.start();
        i_tpc_host.wbyte(`TPC_ADDR_WR, a);
        check(a, 1'b0);
        i_tpc_host.stop();
        @(negedge clk);
        ce = 1'b1;
        rd(`TPC_IDX_CFG, 1);
        check(rb[0], 8'hfe);
        wr(`TPC_IDX_CFG, 8'h01);
        starts(60, k);
        check(k > 0, 1'b1);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        s_reset_vals();
        s_foreign();
        s_press();
        s_repeat();
        s_release();
        s_config();
        summarize();
    end
endmodule
